// ===== hdl/fsr_chan.sv
`timescale 1ns/100ps
module fsr_chan (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic clk_en,
   fsr_chan_if.chan ch
);
   import fsr_pkg::*;

   logic [2:0] cnt_r;
   logic [1:0] rtype;
   logic [2:0] dly;

   assign rtype = ch.cfg[TYPE_HI:TYPE_LO];
   assign dly = ch.cfg[DELAY_HI:DELAY_LO];

   // ----------------------------------------
   // Debounce, only for the debounced type
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cnt_r <= 3'h0;
      end else if (clk_en) begin
         if (!ch.flag) begin
            cnt_r <= 3'h0;
         end else if (ch.tick && cnt_r != dly) begin
            cnt_r <= cnt_r + 3'h1;
         end
      end
   end

   assign ch.qual = ch.flag &&
      (rtype != RSP_DEBOUNCE || cnt_r == dly);

   a_nodeb_type: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (ch.flag && rtype != RSP_DEBOUNCE) |-> ch.qual)
      else $error("undebounced flag not passed through");
   a_deb_wait: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (rtype == RSP_DEBOUNCE && ch.qual && dly != 3'h0) |->
      $past(ch.flag))
      else $error("debounced flag qualified without history");
endmodule

// ===== hdl/fsr_top.sv
`timescale 1ns/100ps
module fsr_top (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic [7:0] reg_cmd,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [15:0] reg_rdata,
   input wire logic supply_on_request,
   input wire logic supply_on_cmd,
   input wire logic [fsr_pkg::MW-1:0] output_voltage_summary_meas,
   input wire logic [fsr_pkg::MW-1:0] output_overvoltage_summary_flim,
   input wire logic [fsr_pkg::MW-1:0] output_overvoltage_summary_wlim,
   input wire logic [fsr_pkg::MW-1:0] output_voltage_summary_uv_wlim,
   input wire logic [fsr_pkg::MW-1:0] output_voltage_summary_uv_flim,
   input wire logic [fsr_pkg::MW-1:0] sensed_line_voltage,
   input wire logic [fsr_pkg::MW-1:0] vin_ov_flim,
   input wire logic [fsr_pkg::MW-1:0] input_undervoltage_summary_wlim,
   input wire logic [fsr_pkg::MW-1:0] input_undervoltage_summary_flim,
   input wire logic [fsr_pkg::MW-1:0] line_turnoff_threshold,
   input wire logic [fsr_pkg::MW-1:0] iin_meas,
   input wire logic [fsr_pkg::MW-1:0] iin_oc_flim,
   input wire logic [fsr_pkg::MW-1:0] iin_oc_wlim,
   input wire logic input_overpower_warning,
   input wire logic [fsr_pkg::MW-1:0] temp_meas,
   input wire logic [fsr_pkg::MW-1:0] ot_flim,
   input wire logic [fsr_pkg::MW-1:0] ot_wlim,
   input wire logic [23:0] vendor_flags,
   input wire logic comms_memory_logic_fault,
   input wire logic other_fault_in,
   input wire logic [4:0] pg_select,
   output logic power_good_pin,
   output logic supply_enable,
   output logic soft_start,
   output logic [2:0] fault_state
);
   import fsr_pkg::*;

   // ----------------------------------------
   // Supply-on pin synchroniser
   // ----------------------------------------
   logic son_s1_r, son_s2_r, son_s3_r, son_pin_r;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         son_s1_r <= 1'b0;
         son_s2_r <= 1'b0;
         son_s3_r <= 1'b0;
         son_pin_r <= 1'b0;
      end else if (clk_en) begin
         son_s1_r <= supply_on_request;
         son_s2_r <= son_s1_r;
         son_s3_r <= son_s2_r;
         // Accept a change only once two stages agree
         if (son_s2_r == son_s3_r) begin
            son_pin_r <= son_s3_r;
         end
      end
   end

   logic supply_on_request_inactive;
   assign supply_on_request_inactive = !(son_pin_r || supply_on_cmd);

   // ----------------------------------------
   // Detailed status from limit comparisons and direct flag inputs
   // ----------------------------------------
   logic output_overvoltage_fault, output_overvoltage_warning;
   logic output_undervoltage_warning, output_undervoltage_fault;
   logic input_overvoltage_fault, input_undervoltage_warning;
   logic input_undervoltage_fault, line_below_turnoff;
   logic input_overcurrent_fault, input_overcurrent_warning;
   logic overtemperature_fault, overtemperature_warning;
   logic fast_overvoltage_comparator_flag;

   assign output_overvoltage_fault = output_voltage_summary_meas > output_overvoltage_summary_flim;
   assign output_overvoltage_warning = output_voltage_summary_meas > output_overvoltage_summary_wlim;
   assign output_undervoltage_warning = output_voltage_summary_meas < output_voltage_summary_uv_wlim;
   assign output_undervoltage_fault = output_voltage_summary_meas < output_voltage_summary_uv_flim;
   assign input_overvoltage_fault =
      sensed_line_voltage > vin_ov_flim;
   assign input_undervoltage_warning =
      sensed_line_voltage < input_undervoltage_summary_wlim;
   assign input_undervoltage_fault =
      sensed_line_voltage < input_undervoltage_summary_flim;
   assign line_below_turnoff =
      sensed_line_voltage < line_turnoff_threshold;
   assign input_overcurrent_fault = iin_meas > iin_oc_flim;
   assign input_overcurrent_warning = iin_meas > iin_oc_wlim;
   assign overtemperature_fault = temp_meas > ot_flim;
   assign overtemperature_warning = temp_meas > ot_wlim;
   assign fast_overvoltage_comparator_flag = vendor_flags[VF_FAST_OVERVOLTAGE_COMPARATOR_FLAG];

   logic [7:0] stat_output_voltage_summary, stat_input, stat_temp;

   // Flags are 1 on the bad condition
   assign stat_output_voltage_summary = {output_overvoltage_fault, output_overvoltage_warning,
      output_undervoltage_warning, output_undervoltage_fault, 4'h0};
   assign stat_input = {input_overvoltage_fault, 1'b0,
      input_undervoltage_warning, input_undervoltage_fault,
      line_below_turnoff, input_overcurrent_fault,
      input_overcurrent_warning, input_overpower_warning};
   assign stat_temp = {overtemperature_fault, overtemperature_warning, 6'h00};

   // ----------------------------------------
   // Power-good flag and pin
   // ----------------------------------------
   logic pg_flag, pg_flag_r;
   logic [4:0] pg_src;

   assign pg_src = {output_undervoltage_fault, output_overvoltage_warning,
      fast_overvoltage_comparator_flag, vendor_flags[VF_OLP],
      vendor_flags[VF_FAST_OCP]};
   assign pg_flag = output_overvoltage_fault || |(pg_src & pg_select);

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pg_flag_r <= 1'b1;
      end else if (clk_en) begin
         pg_flag_r <= pg_flag;
      end
   end

   assign power_good_pin = !pg_flag_r;

   // ----------------------------------------
   // Summary status, always combinational
   // ----------------------------------------
   logic output_overvoltage_summary, input_undervoltage_summary;
   logic temp_summary, output_voltage_summary, input_summary;
   logic vendor_flag_summary, other_fault_bit, unlisted_fault_bit;
   logic [7:0] stat_byte;
   logic [15:0] stat_word;

   assign output_overvoltage_summary =
      output_overvoltage_fault || fast_overvoltage_comparator_flag;
   assign input_undervoltage_summary = input_undervoltage_fault;
   assign temp_summary = |stat_temp;
   assign output_voltage_summary = |stat_output_voltage_summary ||
      fast_overvoltage_comparator_flag;
   assign input_summary = |stat_input;
   assign vendor_flag_summary = |vendor_flags;
   // Everything not carried by bits 7:1 of the byte
   assign other_fault_bit = other_fault_in || output_overvoltage_warning ||
      output_undervoltage_warning || output_undervoltage_fault ||
      input_overvoltage_fault || input_undervoltage_warning ||
      line_below_turnoff || input_overcurrent_fault ||
      input_overcurrent_warning || input_overpower_warning ||
      vendor_flag_summary || pg_flag;
   // Every listed source already has a word bit
   assign unlisted_fault_bit = other_fault_in;

   assign stat_byte = {1'b0, supply_on_request_inactive,
      output_overvoltage_summary, 1'b0, input_undervoltage_summary,
      temp_summary, comms_memory_logic_fault,
      other_fault_bit};
   assign stat_word = {output_voltage_summary, 1'b0, input_summary,
      vendor_flag_summary, pg_flag, 2'b00, unlisted_fault_bit,
      stat_byte};

   // ----------------------------------------
   // Fault-response registers
   // ----------------------------------------
   logic [7:0] resp_r [NCHAN];
   logic [7:0] cmd_of [NCHAN];

   assign cmd_of[CH_VOV] = CMD_OUTPUT_OVERVOLTAGE_SUMMARY_RESP;
   assign cmd_of[CH_VUV] = CMD_OUTPUT_VOLTAGE_SUMMARY_UV_RESP;
   assign cmd_of[CH_OT] = CMD_OT_RESP;
   assign cmd_of[CH_IOV] = CMD_VIN_OV_RESP;
   assign cmd_of[CH_IUV] = CMD_INPUT_UNDERVOLTAGE_SUMMARY_RESP;
   assign cmd_of[CH_IOC] = CMD_IIN_OC_RESP;

   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < NCHAN; i++) begin
         if (sys_rst) begin
            resp_r[i] <= RESP_RST;
         end else if (clk_en && reg_wr && reg_cmd == cmd_of[i]) begin
            resp_r[i] <= reg_wdata;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         reg_rdata <= 16'h0000;
      end else if (clk_en) begin
         unique case (reg_cmd)
            CMD_OUTPUT_OVERVOLTAGE_SUMMARY_RESP: reg_rdata <= {8'h00, resp_r[CH_VOV]};
            CMD_OUTPUT_VOLTAGE_SUMMARY_UV_RESP: reg_rdata <= {8'h00, resp_r[CH_VUV]};
            CMD_OT_RESP: reg_rdata <= {8'h00, resp_r[CH_OT]};
            CMD_VIN_OV_RESP: reg_rdata <= {8'h00, resp_r[CH_IOV]};
            CMD_INPUT_UNDERVOLTAGE_SUMMARY_RESP: reg_rdata <= {8'h00, resp_r[CH_IUV]};
            CMD_IIN_OC_RESP: reg_rdata <= {8'h00, resp_r[CH_IOC]};
            CMD_STAT_BYTE: reg_rdata <= {8'h00, stat_byte};
            CMD_STAT_WORD: reg_rdata <= stat_word;
            CMD_STAT_OUTPUT_VOLTAGE_SUMMARY: reg_rdata <= {8'h00, stat_output_voltage_summary};
            CMD_STAT_INPUT: reg_rdata <= {8'h00, stat_input};
            CMD_STAT_TEMP: reg_rdata <= {8'h00, stat_temp};
            default: reg_rdata <= 16'h0000;
         endcase
      end
   end

   // ----------------------------------------
   // Delay time base
   // ----------------------------------------
   logic [TICK_W-1:0] tick_cnt_r;
   logic tick;

   assign tick = tick_cnt_r == TICK_W'(DELAY_UNIT_CYC - 1);

   always_ff @(posedge clk_sys) begin
      if (sys_rst || (clk_en && tick)) begin
         tick_cnt_r <= '0;
      end else if (clk_en) begin
         tick_cnt_r <= tick_cnt_r + 1'b1;
      end
   end

   // ----------------------------------------
   // Per-fault qualification
   // ----------------------------------------
   logic [NCHAN-1:0] chan_flag, chan_qual;

   assign chan_flag = {input_overcurrent_fault, input_undervoltage_fault,
      input_overvoltage_fault, overtemperature_fault,
      output_undervoltage_fault, output_overvoltage_fault};

   fsr_chan_if cif [NCHAN] ();

   for (genvar g = 0; g < NCHAN; g++) begin : g_chan
      assign cif[g].cfg = resp_r[g];
      assign cif[g].flag = chan_flag[g];
      assign cif[g].tick = tick;
      assign chan_qual[g] = cif[g].qual;
      fsr_chan u_chan (
         .clk_sys(clk_sys),
         .sys_rst(sys_rst),
         .clk_en(clk_en),
         .ch(cif[g])
      );
   end

   // ----------------------------------------
   // Priority pick among active faults
   // ----------------------------------------
   logic win_any;
   logic [1:0] win_type;
   logic [2:0] win_retry, win_delay;

   always_comb begin
      logic [1:0] t;
      logic [2:0] r;
      t = RSP_IGNORE;
      r = RETRY_UNLIMITED;
      win_any = 1'b0;
      win_type = RSP_IGNORE;
      win_retry = RETRY_UNLIMITED;
      win_delay = 3'h0;
      for (int i = 0; i < NCHAN; i++) begin
         t = resp_r[i][TYPE_HI:TYPE_LO];
         r = resp_r[i][RETRY_HI:RETRY_LO];
         // Ignored faults never compete
         if (chan_qual[i] && t != RSP_IGNORE) begin
            if (!win_any || t > win_type ||
               (t == win_type && r < win_retry)) begin
               win_any = 1'b1;
               win_type = t;
               win_retry = r;
               win_delay = resp_r[i][DELAY_HI:DELAY_LO];
            end
         end
      end
   end

   // ----------------------------------------
   // Shutdown and retry sequencer
   // ----------------------------------------
   fsr_state_t state_r;
   logic episode_r;
   logic [2:0] left_r, wait_r, delay_r;
   logic unlimited_r;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_r <= ST_RUN;
         episode_r <= 1'b0;
         left_r <= 3'h0;
         wait_r <= 3'h0;
         delay_r <= 3'h0;
         unlimited_r <= 1'b0;
         soft_start <= 1'b0;
      end else if (clk_en) begin
         soft_start <= 1'b0;
         unique case (state_r)
            ST_RUN: begin
               if (!win_any) begin
                  episode_r <= 1'b0;
               end else if (win_type == RSP_DISABLE) begin
                  state_r <= ST_HOLD;
               end else begin
                  state_r <= ST_OFF;
                  wait_r <= 3'h0;
                  delay_r <= win_delay;
                  episode_r <= 1'b1;
                  if (!episode_r) begin
                     left_r <= win_retry;
                     unlimited_r <= win_retry == RETRY_UNLIMITED;
                  end
               end
            end
            ST_OFF: begin
               if (win_any && win_type == RSP_DISABLE) begin
                  state_r <= ST_HOLD;
               end else if (tick && wait_r != delay_r) begin
                  wait_r <= wait_r + 3'h1;
               end else if (wait_r == delay_r) begin
                  if (left_r == 3'h0 && !unlimited_r) begin
                     state_r <= ST_LATCH;
                  end else begin
                     if (!unlimited_r) begin
                        left_r <= left_r - 3'h1;
                     end
                     state_r <= ST_RUN;
                     soft_start <= !supply_on_request_inactive;
                  end
               end
            end
            ST_HOLD: begin
               // No soft start on leaving
               if (!(win_any && win_type == RSP_DISABLE)) begin
                  state_r <= ST_RUN;
               end
            end
            ST_LATCH: begin
               // Dropping the on request clears the latch
               if (supply_on_request_inactive) begin
                  state_r <= ST_RUN;
                  episode_r <= 1'b0;
               end
            end
            default: state_r <= ST_RUN;
         endcase
      end
   end

   assign supply_enable = state_r == ST_RUN &&
      !line_below_turnoff && !supply_on_request_inactive;
   assign fault_state = {state_r == ST_LATCH, state_r == ST_HOLD,
      state_r == ST_OFF};

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_son_status: assert property (@(posedge clk_sys) disable iff (sys_rst)
      stat_byte[6] == !(son_pin_r || supply_on_cmd))
      else $error("supply-on status bit wrong");
   a_ovp_summary: assert property (@(posedge clk_sys) disable iff (sys_rst)
      stat_byte[5] == (stat_output_voltage_summary[7] || vendor_flags[VF_FAST_OVERVOLTAGE_COMPARATOR_FLAG]))
      else $error("overvoltage summary wrong");
   a_vinuv_mirror: assert property (@(posedge clk_sys) disable iff (sys_rst)
      stat_byte[3] == stat_input[4])
      else $error("input undervoltage mirror wrong");
   a_input_word: assert property (@(posedge clk_sys) disable iff (sys_rst)
      stat_word[13] == (stat_input != 8'h00))
      else $error("input summary wrong");
   a_pg_pin: assert property (@(posedge clk_sys) disable iff (sys_rst)
      clk_en |=> power_good_pin == !$past(pg_flag))
      else $error("power good pin not inverse of flag");
   a_turnoff_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
      line_below_turnoff |-> !supply_enable)
      else $error("supply on below turn-off");
   a_hold_disable: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (clk_en && state_r == ST_RUN && win_any && win_type == RSP_DISABLE)
      |=> state_r == ST_HOLD ##0 !supply_enable)
      else $error("disable response not held");
   a_ignore_run: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (clk_en && state_r == ST_RUN && !win_any) |=> state_r == ST_RUN)
      else $error("left run without active fault");
   a_retry_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (clk_en && state_r == ST_RUN && win_any && win_type != RSP_DISABLE)
      |=> state_r == ST_OFF && !supply_enable)
      else $error("retry response did not shut down");
endmodule

// ===== inc/fsr_chan_if.sv
`timescale 1ns/100ps
interface fsr_chan_if;
   logic [7:0] cfg;
   logic flag;
   logic tick;
   logic qual;
   modport chan(input cfg, input flag, input tick, output qual);
   modport ctl(output cfg, output flag, output tick, input qual);
endinterface

// ===== inc/fsr_pkg.sv
package fsr_pkg;
   // ----------------------------------------
   // Clock and timing
   // ----------------------------------------
   localparam int CLK_MHZ = 50;
   // One step of the delay field, in ns; encoding is not fixed by the part
   localparam int DELAY_UNIT_NS = 10000;
   localparam int DELAY_UNIT_CYC = (DELAY_UNIT_NS * CLK_MHZ) / 1000;
   localparam int TICK_W = 10;

   // ----------------------------------------
   // Command codes (register offsets)
   // ----------------------------------------
   localparam logic [7:0] CMD_OUTPUT_OVERVOLTAGE_SUMMARY_RESP = 8'h41;
   localparam logic [7:0] CMD_OUTPUT_VOLTAGE_SUMMARY_UV_RESP = 8'h45;
   localparam logic [7:0] CMD_OT_RESP = 8'h50;
   localparam logic [7:0] CMD_VIN_OV_RESP = 8'h56;
   localparam logic [7:0] CMD_INPUT_UNDERVOLTAGE_SUMMARY_RESP = 8'h5A;
   localparam logic [7:0] CMD_IIN_OC_RESP = 8'h5C;
   localparam logic [7:0] CMD_STAT_BYTE = 8'h78;
   localparam logic [7:0] CMD_STAT_WORD = 8'h79;
   localparam logic [7:0] CMD_STAT_OUTPUT_VOLTAGE_SUMMARY = 8'h7A;
   localparam logic [7:0] CMD_STAT_INPUT = 8'h7C;
   localparam logic [7:0] CMD_STAT_TEMP = 8'h7D;

   // ----------------------------------------
   // Response register layout
   // ----------------------------------------
   localparam logic [7:0] RESP_RST = 8'h00;
   localparam int TYPE_HI = 7;
   localparam int TYPE_LO = 6;
   localparam int RETRY_HI = 5;
   localparam int RETRY_LO = 3;
   localparam int DELAY_HI = 2;
   localparam int DELAY_LO = 0;
   localparam logic [2:0] RETRY_UNLIMITED = 3'h7;

   typedef enum logic [1:0] {
      RSP_IGNORE = 2'b00,
      RSP_DEBOUNCE = 2'b01,
      RSP_RETRY = 2'b10,
      RSP_DISABLE = 2'b11
   } fsr_rsp_t;

   // ----------------------------------------
   // Channels and vendor flag positions
   // ----------------------------------------
   localparam int NCHAN = 6;
   localparam int CH_VOV = 0;
   localparam int CH_VUV = 1;
   localparam int CH_OT = 2;
   localparam int CH_IOV = 3;
   localparam int CH_IUV = 4;
   localparam int CH_IOC = 5;
   localparam int MW = 12;
   localparam int VF_FAST_OVERVOLTAGE_COMPARATOR_FLAG = 4;
   localparam int VF_OLP = 5;
   localparam int VF_FAST_OCP = 10;

   typedef enum logic [3:0] {
      ST_RUN = 4'b0001,
      ST_OFF = 4'b0010,
      ST_HOLD = 4'b0100,
      ST_LATCH = 4'b1000
   } fsr_state_t;
endpackage

// ===== tb/fsr_host.sv
`timescale 1ns/100ps
// ------------------------------
// Host side of the register port
// ------------------------------
module fsr_host (
   input wire logic clk_sys,
   output logic [7:0] reg_cmd,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   input wire logic [15:0] reg_rdata
);
   initial begin
      reg_cmd = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
   end
   task automatic wr(input logic [7:0] c, input logic [7:0] v);
      @(posedge clk_sys);
      reg_cmd <= c;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   // Read data is registered, so it lands one edge after the code
   task automatic rd(input logic [7:0] c, output logic [15:0] v);
      @(posedge clk_sys);
      reg_cmd <= c;
      @(posedge clk_sys);
      #1;
      v = reg_rdata;
   endtask
endmodule

// ===== tb/tb_status_flags_fault_response.sv
`timescale 1ns/100ps
module tb_status_flags_fault_response;
   import fsr_pkg::*;
   logic clk_sys, sys_rst, clk_en, reg_wr, supply_on_request;
   logic supply_on_cmd, input_overpower_warning, other_fault_in;
   logic comms_memory_logic_fault, power_good_pin, supply_enable;
   logic soft_start;
   logic [7:0] reg_cmd, reg_wdata;
   logic [15:0] reg_rdata, d;
   logic [MW-1:0] output_voltage_summary_meas, output_overvoltage_summary_flim, output_overvoltage_summary_wlim, output_voltage_summary_uv_wlim;
   logic [MW-1:0] output_voltage_summary_uv_flim, sensed_line_voltage, vin_ov_flim;
   logic [MW-1:0] input_undervoltage_summary_wlim, input_undervoltage_summary_flim, line_turnoff_threshold;
   logic [MW-1:0] iin_meas, iin_oc_flim, iin_oc_wlim, temp_meas;
   logic [MW-1:0] ot_flim, ot_wlim;
   logic [23:0] vendor_flags;
   logic [4:0] pg_select;
   logic [2:0] fault_state;
   int errors, num_checks;
   // ------------------------------
   // Clock, design and host
   // ------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   fsr_top DUT (.*);
   fsr_host host (.clk_sys, .reg_cmd, .reg_wr, .reg_wdata, .reg_rdata);
   task automatic chk(input string n, input logic [15:0] e,
                      input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic rv(input logic [7:0] c, input logic [15:0] e);
      host.rd(c, d);
      chk($sformatf("reg %h", c), e, d);
   endtask
   task automatic rb(input logic [7:0] c, input int b, input logic e);
      host.rd(c, d);
      chk($sformatf("reg %h bit %0d", c, b), {15'h0, e}, {15'h0, d[b]});
   endtask
   task automatic en(input logic e);
      chk("supply_enable", {15'h0, e}, {15'h0, supply_enable});
   endtask
   task automatic wfs(input logic [2:0] v, input int n = 40);
      int i;
      for (i = 0; i < n; i++) begin
         @(posedge clk_sys);
         #1;
         if (fault_state === v) break;
      end
      chk("fault_state", {13'h0, v}, {13'h0, fault_state});
      if (i == n) print_verdict();
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic t_regs;
      logic [7:0] c [6] = '{8'h41, 8'h45, 8'h50, 8'h56, 8'h5A, 8'h5C};
      foreach (c[i]) rv(c[i], 16'h0000);
      foreach (c[i]) host.wr(c[i], 8'hC8 + 8'(i));
      foreach (c[i]) rv(c[i], {8'h00, 8'hC8 + 8'(i)});
      foreach (c[i]) host.wr(c[i], 8'h00);
      host.wr(8'h7D, 8'hFF);
      rv(8'h7D, 16'h0000);
      rv(8'h00, 16'h0000);
   endtask
   task automatic t_stat;
      @(posedge clk_sys);
      output_voltage_summary_meas <= 12'h384;
      rv(8'h7A, 16'h00C0);
      rb(8'h78, 5, 1'b1);
      rb(8'h79, 15, 1'b1);
      chk("fault_state", 16'h0, {13'h0, fault_state});
      en(1'b1);
      chk("power_good_pin", 16'h0, {15'h0, power_good_pin});
      @(posedge clk_sys);
      output_voltage_summary_meas <= 12'h064;
      vendor_flags <= 24'h000010;
      rv(8'h7A, 16'h0030);
      rb(8'h78, 5, 1'b1);
      rb(8'h79, 12, 1'b1);
      chk("power_good_pin", 16'h1, {15'h0, power_good_pin});
      @(posedge clk_sys);
      pg_select <= 5'h10;
      rb(8'h79, 11, 1'b1);
      chk("power_good_pin", 16'h0, {15'h0, power_good_pin});
      @(posedge clk_sys);
      output_voltage_summary_meas <= 12'h1F4;
      vendor_flags <= 24'h000000;
      pg_select <= 5'h00;
      sensed_line_voltage <= 12'h0C8;
      rv(8'h7C, 16'h0030);
      rb(8'h78, 3, 1'b1);
      rb(8'h79, 13, 1'b1);
      @(posedge clk_sys);
      sensed_line_voltage <= 12'h050;
      rv(8'h7C, 16'h0038);
      en(1'b0);
      @(posedge clk_sys);
      sensed_line_voltage <= 12'h258;
      iin_meas <= 12'h258;
      input_overpower_warning <= 1'b1;
      temp_meas <= 12'h2BC;
      comms_memory_logic_fault <= 1'b1;
      other_fault_in <= 1'b1;
      rv(8'h7C, 16'h0007);
      rv(8'h7D, 16'h00C0);
      rb(8'h78, 2, 1'b1);
      rb(8'h78, 1, 1'b1);
      rb(8'h78, 0, 1'b1);
      rb(8'h79, 8, 1'b1);
      @(posedge clk_sys);
      iin_meas <= 12'h064;
      input_overpower_warning <= 1'b0;
      temp_meas <= 12'h064;
      comms_memory_logic_fault <= 1'b0;
      other_fault_in <= 1'b0;
   endtask
   task automatic t_retry;
      host.wr(8'h5C, 8'h88);
      @(posedge clk_sys);
      iin_meas <= 12'h258;
      wfs(3'b001);
      @(posedge clk_sys);
      #1;
      chk("soft_start", 16'h0001, {15'h0, soft_start});
      wfs(3'b100);
      en(1'b0);
      @(posedge clk_sys);
      iin_meas <= 12'h064;
      supply_on_request <= 1'b0;
      supply_on_cmd <= 1'b0;
      // Pin path needs three stages plus agreement before it counts
      repeat (4) @(posedge clk_sys);
      rb(8'h78, 6, 1'b1);
      wfs(3'b000);
      @(posedge clk_sys);
      supply_on_request <= 1'b1;
      supply_on_cmd <= 1'b1;
      host.wr(8'h5C, 8'h00);
   endtask
   task automatic t_hold;
      host.wr(8'h50, 8'hC0);
      host.wr(8'h5C, 8'h88);
      @(posedge clk_sys);
      temp_meas <= 12'h2BC;
      iin_meas <= 12'h258;
      wfs(3'b010);
      en(1'b0);
      @(posedge clk_sys);
      temp_meas <= 12'h064;
      iin_meas <= 12'h064;
      wfs(3'b000);
      repeat (6) @(posedge clk_sys);
      en(1'b1);
   endtask
   task automatic unlatch;
      @(posedge clk_sys);
      temp_meas <= 12'h064;
      iin_meas <= 12'h064;
      supply_on_request <= 1'b0;
      supply_on_cmd <= 1'b0;
      wfs(3'b000);
      @(posedge clk_sys);
      supply_on_request <= 1'b1;
      supply_on_cmd <= 1'b1;
      host.wr(8'h50, 8'h00);
      host.wr(8'h5C, 8'h00);
   endtask
   task automatic t_prio;
      host.wr(8'h50, 8'h80);
      host.wr(8'h5C, 8'h88);
      @(posedge clk_sys);
      temp_meas <= 12'h2BC;
      iin_meas <= 12'h258;
      wfs(3'b001);
      @(posedge clk_sys);
      #1;
      // Retry count 0 must win, so no restart in between
      chk("fault_state", 16'h0004, {13'h0, fault_state});
      chk("soft_start", 16'h0000, {15'h0, soft_start});
      unlatch();
   endtask
   task automatic t_deb;
      host.wr(8'h5C, 8'h41);
      @(posedge clk_sys);
      iin_meas <= 12'h258;
      @(posedge clk_sys);
      iin_meas <= 12'h064;
      repeat (4) @(posedge clk_sys);
      #1;
      // A one-cycle glitch never outlasts a one-step debounce
      chk("fault_state", 16'h0000, {13'h0, fault_state});
      @(posedge clk_sys);
      iin_meas <= 12'h258;
      wfs(3'b001, 600);
      wfs(3'b100, 600);
      unlatch();
   endtask
   initial begin
      {sys_rst, clk_en, supply_on_request, supply_on_cmd} = 4'hF;
      {input_overpower_warning, other_fault_in} = 2'b00;
      comms_memory_logic_fault = 1'b0;
      {output_voltage_summary_meas, output_overvoltage_summary_flim, output_overvoltage_summary_wlim} = {12'h1F4, 12'h320, 12'h2BC};
      {output_voltage_summary_uv_wlim, output_voltage_summary_uv_flim} = {12'h12C, 12'h0C8};
      {sensed_line_voltage, vin_ov_flim} = {12'h258, 12'h384};
      {input_undervoltage_summary_wlim, input_undervoltage_summary_flim} = {12'h190, 12'h12C};
      line_turnoff_threshold = 12'h064;
      {iin_meas, iin_oc_flim, iin_oc_wlim} = {12'h064, 12'h1F4, 12'h190};
      {temp_meas, ot_flim, ot_wlim} = {12'h064, 12'h258, 12'h1F4};
      vendor_flags = 24'h000000;
      pg_select = 5'h00;
      repeat (8) @(posedge clk_sys);
      sys_rst <= 1'b0;
      t_regs();
      $display("regs done");
      t_stat();
      $display("status done");
      t_retry();
      $display("retry done");
      t_hold();
      $display("hold done");
      t_prio();
      $display("priority done");
      t_deb();
      $display("debounce done");
      print_verdict();
   end
endmodule
